// File: design/pcm_chan_decode.sv
// combinational decode of one channel's control word into channel states
// assumes inputs are already synchronous and the caller registers the results
`timescale 1ns/100ps
`default_nettype none

module pcm_chan_decode (
  pcm_chan_if.dec ch
);
  import pcm_pkg::*;

  // ****************************************
  // state decode
  // ****************************************
  // low-leak from either source wins over every other control of the driver and the load
  always_comb begin
    logic quiet;
    logic dcl_quiet;
    logic idle_measure_mode;
    quiet = ch.cfg.serial_quiet_bit | ~ch.quiet_pin_n;
    dcl_quiet = quiet | ch.cfg.force_enable_bit;
    // idle mode: nothing forced and nothing measured, so the sense amp is parked
    idle_measure_mode = ~ch.cfg.measure_mode_bit &
      (~ch.quiet_pin_n | (~ch.cfg.force_enable_bit & ch.cfg.force_mode_bit));
    ch.pmu_active = ch.quiet_pin_n & ch.cfg.force_enable_bit;
    // driver level select
    if (dcl_quiet) begin
      ch.drive = PCM_DRV_QUIET;
    end else if (!ch.hv_pin_n) begin
      ch.drive = PCM_DRV_HV;
    end else if (!ch.receive_input) begin
      ch.drive = ch.eff_data ? PCM_DRV_HIGH : PCM_DRV_LOW;
    end else if (ch.cfg.hv_drive_bit) begin
      ch.drive = PCM_DRV_HV;
    end else if (ch.cfg.term_level_select) begin
      ch.drive = PCM_DRV_TERM;
    end else begin
      ch.drive = PCM_DRV_HIZ;
    end
    ch.clamp_en = (ch.drive == PCM_DRV_HIZ);
    // active load
    if (quiet) begin
      ch.load = PCM_LD_QUIET;
    end else if (ch.cfg.load_off_bit) begin
      ch.load = (ch.receive_input && !ch.cfg.term_level_select) ? PCM_LD_HIZ
        : PCM_LD_OFF;
    end else if (ch.cfg.load_force_on_bit) begin
      ch.load = PCM_LD_ON;
    end else if (ch.receive_input && !ch.cfg.term_level_select) begin
      ch.load = PCM_LD_ON;
    end else begin
      ch.load = PCM_LD_OFF;
    end
    // current range, range a only while the unit really forces
    case (ch.cfg.range_field)
      3'h0: ch.range = PCM_RG_E;
      3'h1: ch.range = PCM_RG_D;
      3'h2: ch.range = PCM_RG_C;
      3'h3: ch.range = PCM_RG_B;
      default: ch.range = ch.pmu_active ? PCM_RG_A : PCM_RG_B;
    endcase
    // sense path, grounded in the idle and high-voltage modes
    if (idle_measure_mode || ch.drive == PCM_DRV_HV) begin
      ch.sense = PCM_SN_GND;
    end else begin
      ch.sense = ch.cfg.sense_route_bit ? PCM_SN_EXT : PCM_SN_INT;
    end
  end

endmodule

`default_nettype wire

// File: design/pcm_chan_if.sv
// bundle between the top and one channel decoder
// assumes pcm_pkg is compiled first
`timescale 1ns/100ps
`default_nettype none

interface pcm_chan_if;
  import pcm_pkg::*;
  pcm_cfg_s cfg;
  logic eff_data;
  logic receive_input;
  logic quiet_pin_n;
  logic hv_pin_n;
  pcm_drive_e drive;
  pcm_load_e load;
  pcm_sense_e sense;
  pcm_range_e range;
  logic clamp_en;
  logic pmu_active;

  modport ctl (output cfg, eff_data, receive_input, quiet_pin_n, hv_pin_n,
    input drive, load, sense, range, clamp_en, pmu_active);
  modport dec (input cfg, eff_data, receive_input, quiet_pin_n, hv_pin_n,
    output drive, load, sense, range, clamp_en, pmu_active);
endinterface

`default_nettype wire

// File: design/pcm_params.svh
// constants for the pin channel mode logic: offsets, field positions, reset values
// assumes a 32-bit register bus with byte addresses in the low address bits
`ifndef PCM_PARAMS_SVH
`define PCM_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PCM_OFS_CTRL0 5'h00
`define PCM_OFS_CTRL1 5'h04
`define PCM_OFS_VOFS 5'h08
`define PCM_OFS_IREF 5'h0c
`define PCM_OFS_STAT0 5'h10
`define PCM_OFS_STAT1 5'h14

// ****************************************
// control word field positions
// ****************************************
`define PCM_BIT_INVERT 0
`define PCM_BIT_PARALLEL 1
`define PCM_BIT_DIFF 2
`define PCM_POS_DEADBAND 3
`define PCM_POS_DROOP 6
`define PCM_BIT_LOAD_OFF 9
`define PCM_BIT_LOAD_ON 10
`define PCM_BIT_TERM 11
`define PCM_BIT_QUIET 12
`define PCM_POS_RANGE 13
`define PCM_BIT_FORCE_EN 16
`define PCM_BIT_MEAS_EN 17
`define PCM_BIT_LIMIT_EN 18
`define PCM_BIT_SENSE 19
`define PCM_BIT_FMODE 20
`define PCM_BIT_MMODE 21
`define PCM_BIT_HV 22
`define PCM_CTRL_W 23

// ****************************************
// reset values
// ****************************************
`define PCM_CTRL_RST 23'h000000
`define PCM_DAC_RST 16'h4000
`define PCM_RANGE_B_MAX 3'h3

`endif

// File: design/pcm_pkg.sv
// types shared by the pin channel mode logic and its channel decoder
// assumes pcm_params.svh sits next to it
`include "pcm_params.svh"

package pcm_pkg;

  // per-channel control word, bit 0 at the bottom
  typedef struct packed {
    logic hv_drive_bit;
    logic measure_mode_bit;
    logic force_mode_bit;
    logic sense_route_bit;
    logic limit_enable_bit;
    logic meas_enable_bit;
    logic force_enable_bit;
    logic [2:0] range_field;
    logic serial_quiet_bit;
    logic term_level_select;
    logic load_force_on_bit;
    logic load_off_bit;
    logic [2:0] droop_comp_field;
    logic [2:0] compare_dead_band_field;
    logic diff_compare_bit;
    logic parallel_drive_bit;
    logic invert_bit;
  } pcm_cfg_s;

  typedef enum logic [5:0] {
    PCM_DRV_LOW = 6'h01,
    PCM_DRV_HIGH = 6'h02,
    PCM_DRV_TERM = 6'h04,
    PCM_DRV_HIZ = 6'h08,
    PCM_DRV_HV = 6'h10,
    PCM_DRV_QUIET = 6'h20
  } pcm_drive_e;

  typedef enum logic [3:0] {
    PCM_LD_QUIET = 4'h1,
    PCM_LD_OFF = 4'h2,
    PCM_LD_ON = 4'h4,
    PCM_LD_HIZ = 4'h8
  } pcm_load_e;

  typedef enum logic [2:0] {
    PCM_SN_INT = 3'h1,
    PCM_SN_EXT = 3'h2,
    PCM_SN_GND = 3'h4
  } pcm_sense_e;

  typedef enum logic [4:0] {
    PCM_RG_E = 5'h01,
    PCM_RG_D = 5'h02,
    PCM_RG_C = 5'h04,
    PCM_RG_B = 5'h08,
    PCM_RG_A = 5'h10
  } pcm_range_e;

endpackage

// File: design/pcm_top.sv
// pin channel mode logic: registers, cross-channel steering and registered pin states
// assumes all pins synchronous to core_clk and an avalon-mm master with waitrequest
// What this block does
// - invert bit inverts channel drive data
// - parallel bit drives both from channel 0
// - parallel plus invert on one channel gives complementary outputs
// - clamps on only in high-impedance receive
// - diff bit 0: independent window comparators
// - diff bit 1: difference onto channel 0
// - diff mode forces channel 1 comparator outputs high
// - three-bit hysteresis code, reset zero
// - droop code shared by driver and comparator
// - either low-leak source forces load quiet
// - load on in receive without termination
// - calibrate forces load on, disable overrides
// - range code picks E to A
// - range A falls back to B
// - one bit gates both limit outputs
// - measure output needs bit and pin
// - voltage offset dac resets to 0x4000
// - current reference dac resets to 0x4000
// - sense bit picks pin or external input
// - sense grounded in idle and high-voltage modes
// - driver level from data, receive, termination
// - low-leak pin quiets driver and load and clears pmu_active at once
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pcm_params.svh"

module pcm_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] drive_data_in,
  input wire logic [1:0] receive_input,
  input wire logic [1:0] quiet_pin_n,
  input wire logic [1:0] hv_pin_n,
  input wire logic [1:0] meas_enable_pin,
  input wire logic [1:0] cmp_above_high,
  input wire logic [1:0] cmp_above_low,
  input wire logic diff_above_high,
  input wire logic diff_above_low,
  input wire logic [1:0] meas_over_max,
  input wire logic [1:0] meas_over_min,
  output logic [1:0] drive_data_out,
  output pcm_pkg::pcm_drive_e drive_state_0,
  output pcm_pkg::pcm_drive_e drive_state_1,
  output logic [1:0] clamp_enable,
  output logic [1:0] window_out_high,
  output logic [1:0] window_out_low,
  output logic [5:0] dead_band_code,
  output logic [5:0] droop_code,
  output pcm_pkg::pcm_load_e load_state_0,
  output pcm_pkg::pcm_load_e load_state_1,
  output pcm_pkg::pcm_range_e range_state_0,
  output pcm_pkg::pcm_range_e range_state_1,
  output pcm_pkg::pcm_sense_e sense_state_0,
  output pcm_pkg::pcm_sense_e sense_state_1,
  output logic [1:0] pmu_active,
  output logic [1:0] limit_flag_high_o,
  output logic [1:0] limit_flag_high_oe,
  output logic [1:0] limit_flag_low_o,
  output logic [1:0] limit_flag_low_oe,
  output logic [1:0] meas_out_enable,
  output logic [15:0] volt_offset_dac,
  output logic [15:0] current_ref_dac
);
  import pcm_pkg::*;

  // ****************************************
  // register bus
  // ****************************************
  pcm_cfg_s ctrl_r [2];
  logic [15:0] vofs_r;
  logic [15:0] iref_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_go;
  logic [31:0] stat_w [2];

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] pcm_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // a write lands only on the edge where waitrequest is seen low
  assign wr_go = avs_write && !wait_r;

  // every access answers on the second edge; waitrequest drops for one cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 1'b1;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    case (avs_address)
      `PCM_OFS_CTRL0: rdata_nxt = {9'h000, ctrl_r[0]};
      `PCM_OFS_CTRL1: rdata_nxt = {9'h000, ctrl_r[1]};
      `PCM_OFS_VOFS: rdata_nxt = {16'h0000, vofs_r};
      `PCM_OFS_IREF: rdata_nxt = {16'h0000, iref_r};
      `PCM_OFS_STAT0: rdata_nxt = stat_w[0];
      `PCM_OFS_STAT1: rdata_nxt = stat_w[1];
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data is captured as waitrequest drops and held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // control words, async reset to the power-on defaults
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r[0] <= `PCM_CTRL_RST;
      ctrl_r[1] <= `PCM_CTRL_RST;
    end else if (wr_go && avs_address == `PCM_OFS_CTRL0) begin
      // bits above the control word are dropped on purpose
      ctrl_r[0] <= pcm_cfg_s'(23'(pcm_merge({9'h000, ctrl_r[0]}, avs_writedata,
        avs_byteenable)));
    end else if (wr_go && avs_address == `PCM_OFS_CTRL1) begin
      ctrl_r[1] <= pcm_cfg_s'(23'(pcm_merge({9'h000, ctrl_r[1]}, avs_writedata,
        avs_byteenable)));
    end
  end

  // shared dac codes, full 16-bit range accepted
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vofs_r <= `PCM_DAC_RST;
      iref_r <= `PCM_DAC_RST;
    end else if (wr_go && avs_address == `PCM_OFS_VOFS) begin
      vofs_r <= 16'(pcm_merge({16'h0000, vofs_r}, avs_writedata, avs_byteenable));
    end else if (wr_go && avs_address == `PCM_OFS_IREF) begin
      iref_r <= 16'(pcm_merge({16'h0000, iref_r}, avs_writedata, avs_byteenable));
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign volt_offset_dac = vofs_r;
  assign current_ref_dac = iref_r;

  // ****************************************
  // per-channel decode and registered outputs
  // ****************************************
  logic [1:0] eff_data;
  pcm_drive_e drive_r [2];
  pcm_load_e load_r [2];
  pcm_range_e range_r [2];
  pcm_sense_e sense_r [2];
  logic diff_mode;

  // differential compare is owned by channel 1's control word
  assign diff_mode = ctrl_r[1].diff_compare_bit;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      pcm_chan_if ch ();

      // channel 0 data steers both channels in parallel mode, invert applies after
      assign eff_data[gi] = (ctrl_r[0].parallel_drive_bit ? drive_data_in[0]
        : drive_data_in[gi]) ^ ctrl_r[gi].invert_bit;
      assign ch.cfg = ctrl_r[gi];
      assign ch.eff_data = eff_data[gi];
      assign ch.receive_input = receive_input[gi];
      assign ch.quiet_pin_n = quiet_pin_n[gi];
      assign ch.hv_pin_n = hv_pin_n[gi];

      pcm_chan_decode u_dec (
        .ch(ch)
      );

      // one register stage so every output comes from a flop
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          drive_r[gi] <= PCM_DRV_QUIET;
          load_r[gi] <= PCM_LD_QUIET;
          range_r[gi] <= PCM_RG_E;
          sense_r[gi] <= PCM_SN_GND;
          clamp_enable[gi] <= 1'b0;
          pmu_active[gi] <= 1'b0;
          drive_data_out[gi] <= 1'b0;
        end else begin
          drive_r[gi] <= ch.drive;
          load_r[gi] <= ch.load;
          range_r[gi] <= ch.range;
          sense_r[gi] <= ch.sense;
          clamp_enable[gi] <= ch.clamp_en;
          pmu_active[gi] <= ch.pmu_active;
          drive_data_out[gi] <= eff_data[gi];
        end
      end

      // codes, measure gate and open-drain limit flags
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          dead_band_code[gi*3 +: 3] <= 3'h0;
          droop_code[gi*3 +: 3] <= 3'h0;
          meas_out_enable[gi] <= 1'b0;
          limit_flag_high_o[gi] <= 1'b0;
          limit_flag_low_o[gi] <= 1'b0;
          limit_flag_high_oe[gi] <= 1'b0;
          limit_flag_low_oe[gi] <= 1'b0;
        end else begin
          dead_band_code[gi*3 +: 3] <= ctrl_r[gi].compare_dead_band_field;
          // same droop code feeds the driver and the comparator input
          droop_code[gi*3 +: 3] <= ctrl_r[gi].droop_comp_field;
          meas_out_enable[gi] <= ctrl_r[gi].meas_enable_bit & meas_enable_pin[gi];
          limit_flag_high_o[gi] <= 1'b0;
          limit_flag_low_o[gi] <= 1'b0;
          // high flag pulls low above the max limit, low flag below the min; disabled releases
          limit_flag_high_oe[gi] <= ctrl_r[gi].limit_enable_bit & meas_over_max[gi];
          limit_flag_low_oe[gi] <= ctrl_r[gi].limit_enable_bit & ~meas_over_min[gi];
        end
      end
    end
  endgenerate

  // status words: drive, load, range and sense states side by side
  assign stat_w[0] = {12'h000, pmu_active[0], clamp_enable[0], sense_r[0], range_r[0],
    load_r[0], drive_r[0]};
  assign stat_w[1] = {12'h000, pmu_active[1], clamp_enable[1], sense_r[1], range_r[1],
    load_r[1], drive_r[1]};

  assign drive_state_0 = drive_r[0];
  assign drive_state_1 = drive_r[1];
  assign load_state_0 = load_r[0];
  assign load_state_1 = load_r[1];
  assign range_state_0 = range_r[0];
  assign range_state_1 = range_r[1];
  assign sense_state_0 = sense_r[0];
  assign sense_state_1 = sense_r[1];

  // ****************************************
  // window comparator routing
  // ****************************************
  // differential result rides channel 0; channel 1 parks high so it reads as no edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      window_out_high <= 2'h0;
      window_out_low <= 2'h0;
    end else if (diff_mode) begin
      window_out_high <= {1'b1, diff_above_high};
      window_out_low <= {1'b1, diff_above_low};
    end else begin
      window_out_high <= cmp_above_high;
      window_out_low <= cmp_above_low;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_par_complement:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(ctrl_r[0].parallel_drive_bit && (ctrl_r[0].invert_bit != ctrl_r[1].invert_bit))
    |-> drive_data_out[0] != drive_data_out[1])
    else $error("parallel invert outputs not complementary");
  a_invert_data:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(!ctrl_r[0].parallel_drive_bit && ctrl_r[1].invert_bit)
    |-> drive_data_out[1] == !$past(drive_data_in[1]))
    else $error("channel 1 data not inverted");
  a_parallel_src:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(ctrl_r[0].parallel_drive_bit && !ctrl_r[1].invert_bit)
    |-> drive_data_out[1] == $past(drive_data_in[0]))
    else $error("channel 1 not driven from channel 0 data");
  a_clamp_hiz:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    clamp_enable[0] == (drive_r[0] == PCM_DRV_HIZ))
    else $error("clamp enable disagrees with driver state");
  a_diff_ch1_high:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    diff_mode |=> window_out_high[1] && window_out_low[1])
    else $error("channel 1 comparator not forced high");
  a_diff_route:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(diff_mode) |-> window_out_low[0] == $past(diff_above_low))
    else $error("differential result not on channel 0");
  a_quiet_all:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    !quiet_pin_n[0] |=> load_r[0] == PCM_LD_QUIET && drive_r[0] == PCM_DRV_QUIET
    && !pmu_active[0])
    else $error("low-leak pin did not quiet channel 0");
  a_range_a_gate:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    range_r[0] == PCM_RG_A |-> $past(quiet_pin_n[0] && ctrl_r[0].force_enable_bit))
    else $error("range a outside forcing mode");
  a_limit_release:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(!ctrl_r[1].limit_enable_bit) |-> !limit_flag_high_oe[1] && !limit_flag_low_oe[1])
    else $error("disabled limit flag still driven");
  a_meas_gate:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    meas_out_enable[0] |-> $past(ctrl_r[0].meas_enable_bit && meas_enable_pin[0]))
    else $error("measure output enabled without both controls");
  a_bus_one_wait:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (avs_read || avs_write) && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not released for exactly one cycle");

endmodule

`default_nettype wire

// File: testbench/pcm_fmt_model.sv
// formatter model: drives the fast drive data and receive levels of both channels
// assumes the bench pulses step for one cycle whenever it wants a fresh pattern
`timescale 1ns/100ps
`default_nettype none

module pcm_fmt_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic step,
  output logic [1:0] drive_data,
  output logic [1:0] receive
);
  integer seed = 50;

  // ****************************************
  // pattern source
  // ****************************************
  // levels move only on request, so each check sees one settled pattern
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_data <= 2'h0;
      receive <= 2'h0;
    end else if (step) begin
      drive_data <= 2'($random(seed));
      receive <= 2'($random(seed));
    end
  end
endmodule

`default_nettype wire

// File: testbench/pin_channel_mode_logic_tb_top.sv
// self-checking bench: random control words and pins against a behavioural model
// assumes pcm_pkg and pcm_params.svh are compiled first, formatter model beside it
`timescale 1ns/100ps
`default_nettype none
`include "pcm_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end

module pin_channel_mode_logic_tb_top;
  import pcm_pkg::*;
  logic core_clk, arst_n, avs_read, avs_write, step, ew;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, diff_above_high, diff_above_low;
  logic [1:0] dd, rcv, quiet_pin_n, hv_pin_n, meas_enable_pin, cmp_above_high, cmp_above_low;
  logic [1:0] meas_over_max, meas_over_min, drive_data_out, clamp_enable, pmu_active;
  logic [1:0] window_out_high, window_out_low, meas_out_enable, lh_oe, ll_oe, ed, lh_o, ll_o;
  logic [19:0] st;
  logic [5:0] dead_band_code, droop_code, ds [2];
  logic [3:0] ls [2];
  logic [4:0] rs [2];
  logic [2:0] ss [2];
  logic [15:0] volt_offset_dac, current_ref_dac;
  logic [22:0] w [2];
  integer seed = 50;
  int miscompares = 0, n_compared = 0, cycles = 0;

  pcm_fmt_model fmt_u (.core_clk(core_clk), .arst_n(arst_n), .step(step),
    .drive_data(dd), .receive(rcv));
  pcm_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_data_in(dd), .receive_input(rcv),
    .quiet_pin_n(quiet_pin_n), .hv_pin_n(hv_pin_n), .meas_enable_pin(meas_enable_pin),
    .cmp_above_high(cmp_above_high), .cmp_above_low(cmp_above_low),
    .diff_above_high(diff_above_high), .diff_above_low(diff_above_low),
    .meas_over_max(meas_over_max), .meas_over_min(meas_over_min),
    .drive_data_out(drive_data_out), .drive_state_0(ds[0]), .drive_state_1(ds[1]),
    .clamp_enable(clamp_enable), .window_out_high(window_out_high),
    .window_out_low(window_out_low), .dead_band_code(dead_band_code), .droop_code(droop_code),
    .load_state_0(ls[0]), .load_state_1(ls[1]), .range_state_0(rs[0]), .range_state_1(rs[1]),
    .sense_state_0(ss[0]), .sense_state_1(ss[1]), .pmu_active(pmu_active),
    .limit_flag_high_o(lh_o), .limit_flag_high_oe(lh_oe), .limit_flag_low_o(ll_o),
    .limit_flag_low_oe(ll_oe), .meas_out_enable(meas_out_enable),
    .volt_offset_dac(volt_offset_dac), .current_ref_dac(current_ref_dac));

  // ****************************************
  // clock, watchdog, verdict
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // a hung bus wait must still reach the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // avalon master: request held until waitrequest sampled low
  // ****************************************
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk); // lets the release land before any new request
  endtask

  // ****************************************
  // behavioural model of the channel decode
  // ****************************************
  function automatic logic [5:0] exp_drv(logic [22:0] c, logic qp, logic hp, logic r, logic d);
    if (c[12] || !qp || c[16]) return 6'h20;
    if (!hp) return 6'h10;
    if (!r) return d ? 6'h02 : 6'h01;
    if (c[22]) return 6'h10;
    return c[11] ? 6'h04 : 6'h08;
  endfunction

  function automatic logic [3:0] exp_load(logic [22:0] c, logic qp, logic r);
    if (c[12] || !qp) return 4'h1;
    if (c[9]) return (r && !c[11]) ? 4'h8 : 4'h2;
    return (c[10] || (r && !c[11])) ? 4'h4 : 4'h2;
  endfunction

  function automatic logic [4:0] exp_rng(logic [22:0] c, logic qp);
    if (!c[15]) return 5'h01 << c[14:13];
    return (qp && c[16]) ? 5'h10 : 5'h08;
  endfunction

  function automatic logic [2:0] exp_sns(logic [22:0] c, logic qp, logic [5:0] d);
    if (d == 6'h10 || (!c[21] && (!qp || (!c[16] && c[20])))) return 3'h4;
    return c[19] ? 3'h2 : 3'h1;
  endfunction

  // reset defaults: control words clear, both dacs at 0x4000
  task automatic chk_defaults();
    `CHK(volt_offset_dac, 16'h4000)
    `CHK(current_ref_dac, 16'h4000)
    bus(1'b0, `PCM_OFS_CTRL0, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, `PCM_OFS_CTRL1, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {arst_n, avs_read, avs_write, step, diff_above_high, diff_above_low} = 6'h0;
    {avs_address, avs_writedata, avs_byteenable} = 41'h0f;
    {quiet_pin_n, hv_pin_n, meas_enable_pin} = 6'h3f;
    {cmp_above_high, cmp_above_low, meas_over_max, meas_over_min} = 8'h0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk_defaults();
    bus(1'b0, 5'h18, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, `PCM_OFS_VOFS, 32'h1234ffff);
    bus(1'b0, `PCM_OFS_VOFS, 32'h0);
    `CHK(rd, 32'h0000ffff)
    `CHK(volt_offset_dac, 16'hffff)
    bus(1'b1, `PCM_OFS_IREF, 32'habcd1234);
    bus(1'b0, `PCM_OFS_IREF, 32'h0);
    `CHK(rd, 32'h00001234)
    `CHK(current_ref_dac, 16'h1234)
    for (int i = 0; i < 160; i++) begin
      w[0] = 23'($random(seed));
      w[1] = 23'($random(seed));
      bus(1'b1, `PCM_OFS_CTRL0, {9'h0, w[0]});
      bus(1'b1, `PCM_OFS_CTRL1, {9'h0, w[1]});
      bus(1'b0, `PCM_OFS_CTRL0, 32'h0);
      `CHK(rd, {9'h0, w[0]})
      quiet_pin_n <= 2'($random(seed)) | 2'(i % 2);
      {meas_enable_pin, cmp_above_high, cmp_above_low} <= 6'($random(seed));
      {diff_above_high, diff_above_low, meas_over_max, meas_over_min} <= 6'($random(seed));
      hv_pin_n <= 2'($random(seed)) | 2'h2;
      step <= 1'b1;
      @(posedge core_clk);
      step <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      ed[0] = dd[0] ^ w[0][0];
      ed[1] = (w[0][1] ? dd[0] : dd[1]) ^ w[1][0];
      `CHK(drive_data_out, ed)
      ew = w[1][2];
      `CHK(window_out_high, ew ? {1'b1, diff_above_high} : cmp_above_high)
      `CHK(window_out_low, ew ? {1'b1, diff_above_low} : cmp_above_low)
      `CHK(dead_band_code, {w[1][5:3], w[0][5:3]})
      `CHK(droop_code, {w[1][8:6], w[0][8:6]})
      `CHK(meas_out_enable, {w[1][17], w[0][17]} & meas_enable_pin)
      `CHK((lh_oe | ll_oe) & ~{w[1][18], w[0][18]}, 2'h0)
      `CHK(lh_oe, {w[1][18], w[0][18]} & meas_over_max)
      `CHK(ll_oe, {w[1][18], w[0][18]} & ~meas_over_min)
      `CHK(lh_o | ll_o, 2'h0)
      `CHK(pmu_active, quiet_pin_n & {w[1][16], w[0][16]})
      for (int c = 0; c < 2; c++) begin
        logic [5:0] d;
        d = exp_drv(w[c], quiet_pin_n[c], hv_pin_n[c], rcv[c], ed[c]);
        `CHK(ds[c], d)
        `CHK(clamp_enable[c], d == 6'h08)
        `CHK(ls[c], exp_load(w[c], quiet_pin_n[c], rcv[c]))
        `CHK(rs[c], exp_rng(w[c], quiet_pin_n[c]))
        `CHK(ss[c], exp_sns(w[c], quiet_pin_n[c], d))
        if (c == 0) st = {quiet_pin_n[0] & w[0][16], d == 6'h08,
          exp_sns(w[0], quiet_pin_n[0], d), exp_rng(w[0], quiet_pin_n[0]),
          exp_load(w[0], quiet_pin_n[0], rcv[0]), d};
      end
      @(posedge core_clk);
      // status word mirrors the registered channel 0 states; pins stay put meanwhile
      bus(1'b0, `PCM_OFS_STAT0, 32'h0);
      `CHK(rd, {12'h000, st})
    end
    // second reset after the random loop must restore the dac and control word defaults
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk_defaults();
    summarize();
  end
endmodule

`default_nettype wire
